// ==== design/prac_device.sv ====
// Operation
// - read page code 06, page/count/offset args
// - host gives read count above one
// - authenticate protected pages before reading
// - failed read: error result, stop
// - first addressed page lands in buffer
// - further pages read in turn
// - success: bytes from offset, no-error result
// - write page code 07, page/count/offset args
// - host gives write count above one
// - host keeps write inside buffer
// - authenticate protected pages before writing
// - failed write: error result, stop
// - buffer data goes to first page
// - further pages written in turn
// - success: bytes taken from offset, no-error
// - encrypt code 08, key/iv/offset/count args
// - host selects key and iv 0/1
// - offset in blocks, inside buffer
// - aes-128 cbc over 1..8 blocks
// - encryption touches buffer only, never tag
// - iv chains first block, ciphertext next
// - ciphertext overwrites plaintext in place
`timescale 1ns/100ps
`default_nettype none
module prac_device (
	input  wire logic          clk,
	input  wire logic          reset,
	prac_if.dev                link,
	output logic               tagReq,
	output prac_pkg::prac_tagop_t tagOp,
	output logic [7:0]         tagPage,
	output logic [31:0]        tagWdata,
	input  wire logic          tagAck,
	input  wire logic          tagOk,
	input  wire logic [31:0]   tagRdata,
	output logic               aesReq,
	output logic               aesKeySel,
	output logic [127:0]       aesIn,
	input  wire logic          aesAck,
	input  wire logic [127:0]  aesOut,
	input  wire logic [127:0]  ivZero,
	input  wire logic [127:0]  ivOne
);
	typedef enum logic [2:0] {ST_IDLE, ST_CHECK, ST_AUTH, ST_PAGE, ST_AES, ST_GAP, ST_DONE}
		prac_state_t;

	prac_state_t  state_reg;
	logic [7:0]   code_reg;
	logic [31:0]  args_reg;
	logic [7:0]   page_reg;
	logic [7:0]   count_reg;
	logic [6:0]   ofs_reg;
	logic         keySel_reg;
	logic [127:0] chain_reg;
	logic [7:0]   result_reg;
	logic [7:0]   argErr;
	logic [7:0]   bufMem [prac_pkg::BUF_BYTES];

	// ========================================
	// argument screening
	function automatic logic [7:0] screen(input logic [7:0] code, input logic [31:0] a);
		logic [7:0]  b0;
		logic [7:0]  b1;
		logic [7:0]  b2;
		logic [7:0]  b3;
		logic [10:0] endByte;
		logic [8:0]  endBlk;
		b0 = a[8*0 +: 8];
		b1 = a[8*1 +: 8];
		b2 = a[8*2 +: 8];
		b3 = a[8*3 +: 8];
		endByte = {3'h0, b2} + {1'b0, b1, 2'b00};
		endBlk = {1'b0, b2} + {1'b0, b3};
		screen = prac_pkg::RES_OK;
		if (code == prac_pkg::CMD_READ_PAGE || code == prac_pkg::CMD_WRITE_PAGE) begin
			if (b1 < prac_pkg::MIN_PAGES || endByte > 11'(prac_pkg::BUF_BYTES)) begin
				screen = prac_pkg::RES_ERR_ARG;
			end
		end else if (code == prac_pkg::CMD_ENCRYPT) begin
			if (b0 > prac_pkg::MAX_SEL || b1 > prac_pkg::MAX_SEL
					|| b3 < prac_pkg::MIN_BLOCKS || b3 > prac_pkg::MAX_BLOCKS
					|| endBlk > 9'(prac_pkg::BUF_BYTES / prac_pkg::BLK_BYTES)) begin
				screen = prac_pkg::RES_ERR_ARG;
			end
		end else begin
			screen = prac_pkg::RES_ERR_CMD;
		end
	endfunction

	assign argErr = screen(code_reg, args_reg);

	// ========================================
	// handshakes and data toward tag and cipher
	assign tagReq = (state_reg == ST_AUTH) || (state_reg == ST_PAGE);
	assign tagPage = page_reg;
	assign aesReq = (state_reg == ST_AES);
	assign aesKeySel = keySel_reg;

	always_comb begin
		tagOp = prac_pkg::TAG_AUTH;
		if (state_reg == ST_PAGE) begin
			tagOp = (code_reg == prac_pkg::CMD_READ_PAGE) ? prac_pkg::TAG_READ : prac_pkg::TAG_WRITE;
		end
	end

	always_comb begin
		tagWdata = 32'h0000_0000;
		for (int i = 0; i < prac_pkg::PAGE_BYTES; i++) begin
			tagWdata[31-8*i -: 8] = bufMem[ofs_reg + 7'(i)];
		end
	end

	always_comb begin
		aesIn = chain_reg;
		for (int i = 0; i < prac_pkg::BLK_BYTES; i++) begin
			aesIn[127-8*i -: 8] = chain_reg[127-8*i -: 8] ^ bufMem[ofs_reg + 7'(i)];
		end
	end

	// ========================================
	// command sequencer
	always_ff @(posedge clk) begin
		if (reset) begin
			state_reg <= ST_IDLE;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					if (link.cmdStart) begin
						state_reg <= ST_CHECK;
					end
				end
				ST_CHECK: begin
					if (argErr != prac_pkg::RES_OK) begin
						state_reg <= ST_DONE;
					end else if (code_reg == prac_pkg::CMD_ENCRYPT) begin
						state_reg <= ST_AES;
					end else begin
						state_reg <= ST_AUTH;
					end
				end
				ST_AUTH: begin
					if (tagAck) begin
						state_reg <= tagOk ? ST_GAP : ST_DONE;
					end
				end
				ST_PAGE: begin
					if (tagAck) begin
						if (!tagOk || count_reg == 8'h01) begin
							state_reg <= ST_DONE;
						end else begin
							state_reg <= ST_GAP;
						end
					end
				end
				ST_AES: begin
					if (aesAck) begin
						state_reg <= (count_reg == 8'h01) ? ST_DONE : ST_GAP;
					end
				end
				ST_GAP: begin
					state_reg <= (code_reg == prac_pkg::CMD_ENCRYPT) ? ST_AES : ST_PAGE;
				end
				ST_DONE: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// latch command on start
	always_ff @(posedge clk) begin
		if (reset) begin
			code_reg <= 8'h00;
			args_reg <= prac_pkg::ARG_RESET;
		end else if (state_reg == ST_IDLE && link.cmdStart) begin
			code_reg <= link.cmdCode;
			args_reg <= link.cmdArgs;
		end
	end

	// ========================================
	// walking pointers, count and chaining value
	always_ff @(posedge clk) begin
		if (reset) begin
			page_reg <= 8'h00;
			count_reg <= 8'h00;
			ofs_reg <= 7'h00;
			keySel_reg <= 1'b0;
			chain_reg <= '0;
		end else if (state_reg == ST_CHECK) begin
			if (code_reg == prac_pkg::CMD_ENCRYPT) begin
				count_reg <= args_reg[8*prac_pkg::ARG_ELEN +: 8];
				ofs_reg <= 7'({args_reg[8*prac_pkg::ARG_EOFS +: 8], 4'h0});
				keySel_reg <= args_reg[8*prac_pkg::ARG_KEY];
				chain_reg <= args_reg[8*prac_pkg::ARG_IV] ? ivOne : ivZero;
			end else begin
				page_reg <= args_reg[8*prac_pkg::ARG_PAGE +: 8];
				count_reg <= args_reg[8*prac_pkg::ARG_COUNT +: 8];
				ofs_reg <= 7'(args_reg[8*prac_pkg::ARG_BOFS +: 8]);
			end
		end else if (state_reg == ST_PAGE && tagAck && tagOk) begin
			page_reg <= page_reg + 8'h01;
			count_reg <= count_reg - 8'h01;
			ofs_reg <= ofs_reg + 7'(prac_pkg::PAGE_BYTES);
		end else if (state_reg == ST_AES && aesAck) begin
			chain_reg <= aesOut;
			count_reg <= count_reg - 8'h01;
			ofs_reg <= ofs_reg + 7'(prac_pkg::BLK_BYTES);
		end
	end

	// ========================================
	// shared data buffer; host only writes while idle
	always_ff @(posedge clk) begin
		if (state_reg == ST_IDLE && link.bufWe) begin
			bufMem[link.bufAddr] <= link.bufWdata;
		end else if (state_reg == ST_PAGE && tagAck && tagOk
				&& code_reg == prac_pkg::CMD_READ_PAGE) begin
			for (int i = 0; i < prac_pkg::PAGE_BYTES; i++) begin
				bufMem[ofs_reg + 7'(i)] <= tagRdata[31-8*i -: 8];
			end
		end else if (state_reg == ST_AES && aesAck) begin
			for (int i = 0; i < prac_pkg::BLK_BYTES; i++) begin
				bufMem[ofs_reg + 7'(i)] <= aesOut[127-8*i -: 8];
			end
		end
	end

	assign link.bufRdata = bufMem[link.bufAddr];

	// ========================================
	// result code and completion
	always_ff @(posedge clk) begin
		if (reset) begin
			result_reg <= prac_pkg::RES_OK;
		end else if (state_reg == ST_CHECK) begin
			result_reg <= argErr;
		end else if ((state_reg == ST_AUTH || state_reg == ST_PAGE) && tagAck && !tagOk) begin
			result_reg <= prac_pkg::RES_ERR_TAG;
		end
	end
	// ok stays from the check unless the tag fails, so success reports no-error

	assign link.result = result_reg;
	assign link.busy = (state_reg != ST_IDLE);
	assign link.done = (state_reg == ST_DONE);
endmodule
`default_nettype wire

// ==== design/prac_pkg.sv ====
package prac_pkg;
	// ========================================
	// command codes and argument byte slots
	localparam logic [7:0] CMD_READ_PAGE  = 8'h06;
	localparam logic [7:0] CMD_WRITE_PAGE = 8'h07;
	localparam logic [7:0] CMD_ENCRYPT    = 8'h08;
	localparam int ARG_PAGE  = 0;
	localparam int ARG_COUNT = 1;
	localparam int ARG_BOFS  = 2;
	localparam int ARG_KEY   = 0;
	localparam int ARG_IV    = 1;
	localparam int ARG_EOFS  = 2;
	localparam int ARG_ELEN  = 3;
	// ========================================
	// result codes
	localparam logic [7:0] RES_OK      = 8'h00;
	localparam logic [7:0] RES_ERR_TAG = 8'h01;
	localparam logic [7:0] RES_ERR_ARG = 8'h02;
	localparam logic [7:0] RES_ERR_CMD = 8'h03;
	// ========================================
	// buffer geometry
	localparam int BUF_BYTES  = 128;
	localparam int IDX_W      = 7;
	localparam int PAGE_BYTES = 4;
	localparam int BLK_BYTES  = 16;
	localparam logic [7:0] MIN_PAGES  = 8'h02;
	localparam logic [7:0] MIN_BLOCKS = 8'h01;
	localparam logic [7:0] MAX_BLOCKS = 8'h08;
	localparam logic [7:0] MAX_SEL    = 8'h01;
	// ========================================
	// tag operations
	typedef enum logic [1:0] {TAG_AUTH, TAG_READ, TAG_WRITE} prac_tagop_t;
	// ========================================
	// host register map (byte addresses) and status fields
	localparam logic [7:0] REG_CMD  = 8'h00;
	localparam logic [7:0] REG_ARG  = 8'h04;
	localparam logic [7:0] REG_STAT = 8'h08;
	localparam logic [7:0] REG_BUFA = 8'h0C;
	localparam logic [7:0] REG_BUFD = 8'h10;
	localparam int STAT_DONE = 0;
	localparam int STAT_BUSY = 1;
	localparam int STAT_RES  = 8;
	localparam logic [31:0] ARG_RESET = 32'h0000_0000;
endpackage

// ==== design/prac_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface prac_if;
	logic        cmdStart;
	logic [7:0]  cmdCode;
	logic [31:0] cmdArgs;
	logic        busy;
	logic        done;
	logic [7:0]  result;
	logic [6:0]  bufAddr;
	logic        bufWe;
	logic [7:0]  bufWdata;
	logic [7:0]  bufRdata;
	modport dev (input cmdStart, cmdCode, cmdArgs, bufAddr, bufWe, bufWdata,
		output busy, done, result, bufRdata);
	modport host (output cmdStart, cmdCode, cmdArgs, bufAddr, bufWe, bufWdata,
		input busy, done, result, bufRdata);
endinterface
`default_nettype wire

// ==== design/prac_host.sv ====
`timescale 1ns/100ps
`default_nettype none
module prac_host (
	input  wire logic        clk,
	input  wire logic        reset,
	prac_if.host             link,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr
);
	logic        access;
	logic        wrAcc;
	logic        rdAcc;
	logic        mapped;
	logic [7:0]  code_reg;
	logic [31:0] args_reg;
	logic        start_reg;
	logic        done_reg;
	logic [6:0]  bufAddr_reg;

	// ========================================
	// apb decode; zero wait states
	assign access = psel && penable;
	assign wrAcc = access && pwrite;
	assign rdAcc = access && !pwrite;
	assign mapped = (paddr == prac_pkg::REG_CMD) || (paddr == prac_pkg::REG_ARG)
		|| (paddr == prac_pkg::REG_STAT) || (paddr == prac_pkg::REG_BUFA)
		|| (paddr == prac_pkg::REG_BUFD);
	assign pready = 1'b1;
	assign pslverr = access && !mapped;

	always_comb begin
		prdata = 32'h0000_0000;
		unique case (paddr)
			prac_pkg::REG_CMD:  prdata = {24'h00_0000, code_reg};
			prac_pkg::REG_ARG:  prdata = args_reg;
			prac_pkg::REG_STAT: begin
				prdata[prac_pkg::STAT_DONE] = done_reg;
				prdata[prac_pkg::STAT_BUSY] = link.busy;
				prdata[prac_pkg::STAT_RES +: 8] = link.result;
			end
			prac_pkg::REG_BUFA: prdata = {25'h000_0000, bufAddr_reg};
			prac_pkg::REG_BUFD: prdata = {24'h00_0000, link.bufRdata};
			default:            prdata = 32'h0000_0000;
		endcase
	end

	// ========================================
	// command issue; a write while busy is dropped
	always_ff @(posedge clk) begin
		if (reset) begin
			code_reg <= 8'h00;
			args_reg <= prac_pkg::ARG_RESET;
			start_reg <= 1'b0;
		end else begin
			start_reg <= 1'b0;
			if (wrAcc && paddr == prac_pkg::REG_ARG && !link.busy) begin
				args_reg <= pwdata;
			end
			if (wrAcc && paddr == prac_pkg::REG_CMD && !link.busy && !start_reg) begin
				code_reg <= pwdata[7:0];
				start_reg <= 1'b1;
			end
		end
	end

	// sticky done; a new completion beats the read that clears it
	always_ff @(posedge clk) begin
		if (reset) begin
			done_reg <= 1'b0;
		end else if (link.done) begin
			done_reg <= 1'b1;
		end else if (rdAcc && paddr == prac_pkg::REG_STAT) begin
			done_reg <= 1'b0;
		end
	end

	// ========================================
	// buffer window, auto-incrementing
	always_ff @(posedge clk) begin
		if (reset) begin
			bufAddr_reg <= 7'h00;
		end else if (wrAcc && paddr == prac_pkg::REG_BUFA) begin
			bufAddr_reg <= pwdata[6:0];
		end else if (access && paddr == prac_pkg::REG_BUFD) begin
			bufAddr_reg <= bufAddr_reg + 7'h01;
		end
	end

	assign link.cmdStart = start_reg;
	assign link.cmdCode = code_reg;
	assign link.cmdArgs = args_reg;
	assign link.bufAddr = bufAddr_reg;
	assign link.bufWe = wrAcc && paddr == prac_pkg::REG_BUFD && !link.busy;
	assign link.bufWdata = pwdata[7:0];
endmodule
`default_nettype wire

// ==== tb/prac_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
module prac_monitor (
	input wire logic        clk,
	input wire logic        reset,
	input wire logic        cmdStart,
	input wire logic [7:0]  cmdCode,
	input wire logic [31:0] cmdArgs,
	input wire logic        busy,
	input wire logic        done,
	input wire logic [7:0]  result
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// ========================================
	// helpers
	logic taken;
	logic isEnc;
	assign taken = cmdStart && !busy;
	assign isEnc = cmdCode == prac_pkg::CMD_ENCRYPT;
	sequence s_check;
		busy && !done;
	endsequence
	sequence s_reject;
		done && result == prac_pkg::RES_ERR_ARG;
	endsequence
	// ========================================
	// properties
	chk_start_busy: assert property (taken |=> s_check)
		else $error("start not taken");
	chk_count_low: assert property (taken && cmdArgs[15:8] < prac_pkg::MIN_PAGES
		&& (cmdCode == prac_pkg::CMD_READ_PAGE || cmdCode == prac_pkg::CMD_WRITE_PAGE)
		|-> ##2 s_reject) else $error("short page count accepted");
	chk_sel_range: assert property (taken && isEnc && (cmdArgs[7:0] > prac_pkg::MAX_SEL
		|| cmdArgs[15:8] > prac_pkg::MAX_SEL) |-> ##2 s_reject) else $error("bad selector accepted");
	chk_len_range: assert property (taken && isEnc && (cmdArgs[31:24] < prac_pkg::MIN_BLOCKS
		|| cmdArgs[31:24] > prac_pkg::MAX_BLOCKS
		|| {1'b0, cmdArgs[23:16]} + {1'b0, cmdArgs[31:24]} > 9'h008)
		|-> ##2 s_reject) else $error("bad block range accepted");
	chk_code_unknown: assert property (taken && cmdCode != prac_pkg::CMD_READ_PAGE
		&& cmdCode != prac_pkg::CMD_WRITE_PAGE && !isEnc
		|-> ##[1:4] (done && result == prac_pkg::RES_ERR_CMD)) else $error("unknown code accepted");
	chk_done_pulse: assert property (done |=> !done)
		else $error("done longer than a cycle");
	chk_done_idle: assert property (done |-> busy ##1 !busy)
		else $error("busy after done");
	chk_result_hold: assert property (!busy |=> $stable(result))
		else $error("result moved while idle");
	// bench partners answer one cycle after each request, so a command never runs long
	chk_busy_bound: assert property ($rose(busy) |-> ##[1:400] done)
		else $error("command never ended");
endmodule
`default_nettype wire

// ==== tb/page_rw_aes_cbc_commands_test.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin errCount++; \
	$display("unexpected %s exp %h got %h", n, e, g); end end
module page_rw_aes_cbc_commands_test;
	localparam logic [127:0] IV0 = 128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0;
	localparam logic [127:0] IV1 = 128'h00112233445566778899AABBCCDDEEFF;
	logic                  clk, reset, psel, penable, pwrite, pready, pslverr, lastErr;
	logic [7:0]            paddr, tagPage, failPage;
	logic [31:0]           pwdata, prdata, tagWdata;
	logic [31:0]           tagRdata = 32'h0000_0000;
	logic                  tagReq, aesReq, aesKeySel;
	logic                  tagAck = 1'b0, tagOk = 1'b0, aesAck = 1'b0;
	prac_pkg::prac_tagop_t tagOp;
	logic [127:0]          aesIn;
	logic [127:0]          aesOut = '0;
	logic [7:0]            mem [128];
	logic [39:0]           wrLog [$];
	int                    errCount, checks, tagCount;
	prac_if link ();
	prac_device prac_device_i (.clk, .reset, .link(link.dev), .tagReq, .tagOp, .tagPage,
		.tagWdata, .tagAck, .tagOk, .tagRdata, .aesReq, .aesKeySel, .aesIn, .aesAck,
		.aesOut, .ivZero(IV0), .ivOne(IV1));
	prac_host prac_host_i (.clk, .reset, .link(link.host), .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr);
	prac_monitor prac_monitor_i (.clk, .reset, .cmdStart(link.cmdStart),
		.cmdCode(link.cmdCode), .cmdArgs(link.cmdArgs), .busy(link.busy),
		.done(link.done), .result(link.result));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// ========================================
	// far side: tag and cipher answer one cycle after the request
	function automatic logic [31:0] pg(input logic [7:0] p);
		return {p, ~p, p ^ 8'h5A, 8'hC3};
	endfunction
	always @(posedge clk) begin
		if (tagReq && !tagAck) begin
			tagAck <= 1'b1;
			// a failing first page refuses the auth step too, so the command stops early
			tagOk <= tagPage != failPage;
			tagRdata <= pg(tagPage);
			tagCount <= tagCount + 1;
			if (tagOp == prac_pkg::TAG_WRITE)
				wrLog.push_back({tagPage, tagWdata});
		end else begin
			tagAck <= 1'b0;
			tagRdata <= ~tagRdata;
		end
		// toy cipher: key-dependent xor, enough to see chaining and key choice
		aesAck <= aesReq && !aesAck;
		aesOut <= (aesReq && !aesAck) ? aesIn ^ {16{aesKeySel ? 8'hA5 : 8'h3C}} : ~aesOut;
	end
	// ========================================
	// bus tasks
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		lastErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic run(input logic [7:0] c, input logic [31:0] args, input logic [7:0] res);
		logic [31:0] r;
		apb(1'b1, prac_pkg::REG_ARG, args, r);
		apb(1'b1, prac_pkg::REG_CMD, {24'h000000, c}, r);
		apb(1'b0, prac_pkg::REG_STAT, 32'h00000000, r);
		`CHK("busy", 1'b1, r[1])
		while (r[0] !== 1'b1)
			apb(1'b0, prac_pkg::REG_STAT, 32'h00000000, r);
		`CHK("idle", 1'b0, r[1])
		`CHK("result", res, r[15:8])
	endtask
	task automatic bufIo(input logic w, input int a, input int n);
		logic [31:0] r;
		apb(1'b1, prac_pkg::REG_BUFA, 32'(a), r);
		for (int i = a; i < a + n; i++) begin
			apb(w, prac_pkg::REG_BUFD, {24'h000000, mem[i]}, r);
			if (!w) `CHK("buffer", mem[i], r[7:0])
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, errCount);
		if (errCount == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge clk);
		errCount++;
		conclude();
	end
	// ========================================
	// tests
	initial begin
		logic [39:0]  bad [7];
		logic [39:0]  expW;
		logic [127:0] chain, blk;
		logic [31:0]  r;
		int           tc, ofs, n;
		bad = '{40'h0600000100, 40'h0700000100, 40'h0801000002, 40'h0801000200,
			40'h0800000000, 40'h0809000000, 40'h0802070000};
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{errCount, checks, failPage} = {32'h0, 32'h0, 8'hFF};
		reset = 1'b1;
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		for (int i = 0; i < 128; i++)
			mem[i] = 8'(i) ^ 8'h5C;
		bufIo(1'b1, 0, 128);
		tc = tagCount;
		run(prac_pkg::CMD_READ_PAGE, 32'h0005030A, prac_pkg::RES_OK);
		`CHK("tag ops", tc + 4, tagCount)
		for (int i = 0; i < 12; i++)
			mem[5 + i] = 8'(pg(8'(10 + i / 4)) >> (24 - 8 * (i % 4)));
		bufIo(1'b0, 4, 14);
		$display("test read ended");
		run(prac_pkg::CMD_WRITE_PAGE, 32'h00280214, prac_pkg::RES_OK);
		`CHK("writes", 2, wrLog.size())
		for (int k = 0; k < 2; k++) begin
			expW = {8'(20 + k), mem[40 + 4 * k], mem[41 + 4 * k],
				mem[42 + 4 * k], mem[43 + 4 * k]};
			`CHK("page", expW, wrLog[k])
		end
		$display("test write ended");
		failPage = 8'h1F;
		run(prac_pkg::CMD_READ_PAGE, 32'h003C031E, prac_pkg::RES_ERR_TAG);
		for (int i = 0; i < 4; i++)
			mem[60 + i] = 8'(pg(8'h1E) >> (24 - 8 * i));
		bufIo(1'b0, 60, 8);
		wrLog.delete();
		run(prac_pkg::CMD_WRITE_PAGE, 32'h0000031E, prac_pkg::RES_ERR_TAG);
		`CHK("writes", 2, wrLog.size())
		tc = tagCount;
		run(prac_pkg::CMD_READ_PAGE, 32'h0000021F, prac_pkg::RES_ERR_TAG);
		`CHK("tag ops", tc + 1, tagCount)
		failPage = 8'hFF;
		$display("test tag fault ended");
		tc = tagCount;
		for (int i = 0; i < 7; i++)
			run(bad[i][39:32], bad[i][31:0], prac_pkg::RES_ERR_ARG);
		run(8'h09, 32'h00000000, prac_pkg::RES_ERR_CMD);
		`CHK("tag use", tc, tagCount)
		bufIo(1'b0, 0, 128);
		$display("test reject ended");
		for (int t = 0; t < 2; t++) begin
			chain = t ? IV1 : IV0;
			ofs = t ? 7 : 2;
			n = t ? 1 : 2;
			for (int b = 0; b < n; b++) begin
				for (int j = 0; j < 16; j++)
					blk[127 - 8 * j -: 8] = mem[16 * (ofs + b) + j];
				chain = chain ^ blk ^ {16{t ? 8'h3C : 8'hA5}};
				for (int j = 0; j < 16; j++)
					mem[16 * (ofs + b) + j] = chain[127 - 8 * j -: 8];
			end
			run(prac_pkg::CMD_ENCRYPT, {8'(n), 8'(ofs), 8'(t), 8'(1 - t)},
				prac_pkg::RES_OK);
			`CHK("tag use", tc, tagCount)
		end
		bufIo(1'b0, 0, 128);
		$display("test encrypt ended");
		apb(1'b0, prac_pkg::REG_ARG, 32'h00000000, r);
		`CHK("args", 32'h01070100, r)
		apb(1'b0, prac_pkg::REG_CMD, 32'h00000000, r);
		`CHK("code", {24'h000000, prac_pkg::CMD_ENCRYPT}, r)
		apb(1'b0, 8'h40, 32'h00000000, r);
		`CHK("pslverr", 1'b1, lastErr)
		$display("test bus ended");
		conclude();
	end
endmodule
`default_nettype wire
